// ===== hdl/dual_function_power_manager.sv
`timescale 1ns/1ns
`default_nettype none
module dual_function_power_manager #(
  parameter logic [pm_pkg::PD_CNT_W-1:0] PD_SHORT_CYC = pm_pkg::FILT_SHORT_CYC,
  parameter logic [pm_pkg::PD_CNT_W-1:0] PD_MID_CYC = pm_pkg::FILT_MID_CYC,
  parameter logic [pm_pkg::PD_CNT_W-1:0] PD_LONG_CYC = pm_pkg::FILT_LONG_CYC,
  parameter logic [pm_pkg::PD_CNT_W-1:0] PD_LONG_IRQ_CYC = pm_pkg::FILT_LONG_IRQ_CYC
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // Serial channel activity
  input wire logic [pm_pkg::N_CHAN-1:0] chan_irq_pending_i,
  input wire logic [pm_pkg::N_CHAN-1:0] chan_tx_idle_i,
  input wire logic [pm_pkg::N_CHAN-1:0] chan_rx_idle_i,
  input wire logic [pm_pkg::N_CHAN-1:0] chan_uart_irq_i,
  // Serial channel wake inputs
  input wire logic [pm_pkg::N_CHAN*pm_pkg::MODEM_W-1:0] modem_status_i,
  input wire logic [pm_pkg::N_CHAN-1:0] ring_indicator_input_n_i,
  input wire logic [pm_pkg::N_CHAN-1:0] serial_data_input_i,
  input wire logic wake_mask_wr_i,
  input wire logic [pm_pkg::N_CHAN*(pm_pkg::MODEM_W+1)-1:0] wake_mask_wdata_i,
  output logic [pm_pkg::N_CHAN*(pm_pkg::MODEM_W+1)-1:0] wake_mask_o,
  // Local control and interrupt configuration
  input wire logic [1:0] pd_filter_sel_i,
  input wire logic mpp1_irq_mask_i,
  input wire logic f1_wake_en_i,
  input wire logic [1:0] f1_wake_edge_sel_i,
  input wire logic [pm_pkg::MPP_W-1:0] multi_purpose_pin_i,
  input wire logic [pm_pkg::MPP_W-1:0] mpp_invert_i,
  input wire logic [pm_pkg::N_F1_PD-1:0] f1_pd_pin_en_i,
  input wire logic f1_pd_irq_en_i,
  input wire logic f1_irq_src_i,
  // Power management control/status writes per function
  input wire logic [1:0] pmcsr_wr_i,
  input wire logic [pm_pkg::PMCSR_W-1:0] pmcsr_wdata0_i,
  input wire logic [pm_pkg::PMCSR_W-1:0] pmcsr_wdata1_i,
  output logic [pm_pkg::PMCSR_W-1:0] pmcsr_rdata0_o,
  output logic [pm_pkg::PMCSR_W-1:0] pmcsr_rdata1_o,
  // Results
  output logic pd_status_o,
  output logic f0_irq_o,
  output logic f1_irq_o,
  output logic f1_pd_req_o,
  output logic [pm_pkg::N_CHAN-1:0] chan_clk_en_o,
  output logic f0_bar_en_o,
  output logic f1_bar_en_o,
  output logic f1_low_power_o,
  output logic pme_n_o
);
  localparam int NC = pm_pkg::N_CHAN;
  localparam int MW = pm_pkg::MODEM_W;
  localparam int EW = NC * MW + NC * 2 + 1;

  pm_pkg::pwr_state_t ps_reg [2];
  logic [1:0] pme_en_reg;
  logic [1:0] pme_st_reg;
  logic [NC*(MW+1)-1:0] wake_mask_reg;
  logic [NC-1:0] sin_wake_reg;
  logic [pm_pkg::PMCSR_W-1:0] wdata [2];
  logic [1:0] low_pwr;
  logic [1:0] wake;
  logic [1:0] w1c;

  // Image of a control/status word; reserved bits read zero
  function automatic logic [pm_pkg::PMCSR_W-1:0] pmcsr_image(input pm_pkg::pwr_state_t s,
                                                             input logic en, input logic st);
    logic [pm_pkg::PMCSR_W-1:0] v;
    v = '0;
    v[1:0] = pm_pkg::ps_code(s);
    v[pm_pkg::PMCSR_PME_EN] = en;
    v[pm_pkg::PMCSR_PME_ST] = st;
    return v;
  endfunction

  assign wdata[0] = pmcsr_wdata0_i;
  assign wdata[1] = pmcsr_wdata1_i;

  // Write-one-to-clear strobes and low-power decode
  always_comb begin
    for (int f = 0; f < 2; f++) begin
      w1c[f] = pmcsr_wr_i[f] && wdata[f][pm_pkg::PMCSR_PME_ST];
      low_pwr[f] = ps_reg[f] != pm_pkg::PS_D0;
    end
  end

  // Power state moves only on a driver write, never on its own
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ps_reg[0] <= pm_pkg::PS_D0;
      ps_reg[1] <= pm_pkg::PS_D0;
    end else if (clk_en_i) begin
      for (int f = 0; f < 2; f++) begin
        if (pmcsr_wr_i[f]) begin
          ps_reg[f] <= pm_pkg::ps_decode(wdata[f][1:0], ps_reg[f]);
        end
      end
    end
  end

  // Wake enable bits follow driver writes
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      pme_en_reg <= '0;
    end else if (clk_en_i) begin
      for (int f = 0; f < 2; f++) begin
        if (pmcsr_wr_i[f]) begin
          pme_en_reg[f] <= wdata[f][pm_pkg::PMCSR_PME_EN];
        end
      end
    end
  end

  // Sticky wake status: a wake in the clearing cycle still sets it
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      pme_st_reg <= '0;
    end else if (clk_en_i) begin
      pme_st_reg <= (pme_st_reg & ~w1c) | wake;
    end
  end

  // Wake is a plain gate of status and enable, no filter in the path
  assign pme_n_o = ~|(pme_st_reg & pme_en_reg);
  assign pmcsr_rdata0_o = pmcsr_image(ps_reg[0], pme_en_reg[0], pme_st_reg[0]);
  assign pmcsr_rdata1_o = pmcsr_image(ps_reg[1], pme_en_reg[1], pme_st_reg[1]);

  // D2 wake masks: set bit suppresses; reset leaves every source armed
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      wake_mask_reg <= '0;
    end else if (clk_en_i && wake_mask_wr_i) begin
      wake_mask_reg <= wake_mask_wdata_i;
    end
  end
  assign wake_mask_o = wake_mask_reg;

  // One detector covers modem lines, data inputs, ring inputs and pin 2
  logic [EW-1:0] ev_level;
  logic [EW-1:0] ev_rise;
  logic [EW-1:0] ev_fall;
  assign ev_level = {multi_purpose_pin_i[pm_pkg::MPP_WAKE], ring_indicator_input_n_i,
                     serial_data_input_i, modem_status_i};

  level_edge_detect #(
    .W(EW)
  ) u_edges (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .level_i(ev_level),
    .rise_o(ev_rise),
    .fall_o(ev_fall)
  );

  logic [NC*MW-1:0] modem_chg;
  logic [NC-1:0] sin_chg;
  logic [NC-1:0] ri_trail;
  logic pin2_rise;
  logic pin2_fall;
  logic [NC-1:0] d2_wake;
  logic [NC-1:0] d3_wake;
  logic [NC-1:0] sin_wake;

  assign modem_chg = ev_rise[NC*MW-1:0] | ev_fall[NC*MW-1:0];
  assign sin_chg = ev_rise[NC*MW+NC-1:NC*MW] | ev_fall[NC*MW+NC-1:NC*MW];
  // Ring input is active low, so the trailing edge is its rise
  assign ri_trail = ev_rise[NC*MW+2*NC-1:NC*MW+NC];
  assign pin2_rise = ev_rise[EW-1];
  assign pin2_fall = ev_fall[EW-1];

  // Per-channel wake sources by power state
  always_comb begin
    for (int c = 0; c < NC; c++) begin
      sin_wake[c] = sin_chg[c] && !wake_mask_reg[NC*MW+c];
      d2_wake[c] = |(modem_chg[c*MW +: MW] & ~wake_mask_reg[c*MW +: MW]) || sin_wake[c];
      d3_wake[c] = ri_trail[c];
    end
  end

  // Function 0 wakes only from a low-power state; function 1 from pin 2
  always_comb begin
    case (ps_reg[0])
      pm_pkg::PS_D2: wake[0] = |d2_wake;
      pm_pkg::PS_D3: wake[0] = |d3_wake;
      default: wake[0] = 1'b0;
    endcase
    case (f1_wake_edge_sel_i)
      pm_pkg::WAKE_EDGE_RISE: wake[1] = f1_wake_en_i && pin2_rise;
      pm_pkg::WAKE_EDGE_FALL: wake[1] = f1_wake_en_i && pin2_fall;
      default: wake[1] = 1'b0;
    endcase
  end

  // Data-input wake from D2 keeps that channel clocked until back in D0
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      sin_wake_reg <= '0;
    end else if (clk_en_i) begin
      if (!low_pwr[0]) begin
        sin_wake_reg <= '0;
      end else if (ps_reg[0] == pm_pkg::PS_D2) begin
        sin_wake_reg <= sin_wake_reg | sin_wake;
      end
    end
  end

  // Channel idle means no pending interrupt and both directions idle
  logic all_idle;
  logic pd_valid;
  logic [pm_pkg::PD_CNT_W-1:0] pd_limit;
  assign all_idle = &(~chan_irq_pending_i & chan_tx_idle_i & chan_rx_idle_i);

  // Longest setting differs slightly when the interrupt is enabled
  always_comb begin
    case (pd_filter_sel_i)
      pm_pkg::FILT_SHORT: pd_limit = PD_SHORT_CYC;
      pm_pkg::FILT_MID: pd_limit = PD_MID_CYC;
      pm_pkg::FILT_LONG: pd_limit = mpp1_irq_mask_i ? PD_LONG_IRQ_CYC : PD_LONG_CYC;
      default: pd_limit = PD_SHORT_CYC;
    endcase
  end

  idle_time_filter u_filter (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .idle_i(all_idle),
    .sel_i(pd_filter_sel_i),
    .limit_i(pd_limit),
    .valid_o(pd_valid)
  );

  // Pin levels after the configured inversion
  logic [pm_pkg::MPP_W-1:0] mpp_act;
  logic f0_pd_src;
  logic pd_status_next;
  logic f0_irq_next;
  logic f1_pd_next;
  logic f1_irq_next;
  assign mpp_act = multi_purpose_pin_i ^ mpp_invert_i;

  // Shared status bit: pin 1 when filter off, else filtered power-down
  always_comb begin
    if (pd_filter_sel_i == pm_pkg::FILT_OFF) begin
      pd_status_next = mpp_act[pm_pkg::MPP_F0];
      f0_pd_src = mpp_act[pm_pkg::MPP_F0] && mpp1_irq_mask_i;
    end else begin
      pd_status_next = pd_valid;
      f0_pd_src = pd_valid && mpp1_irq_mask_i;
    end
    f0_irq_next = !low_pwr[0] && (|chan_uart_irq_i || f0_pd_src);
  end

  // Function 1 power-down is purely pin driven; ports add no sources
  assign f1_pd_next = |(mpp_act[pm_pkg::MPP_W-1:pm_pkg::MPP_PD_LO] & f1_pd_pin_en_i);
  assign f1_irq_next = !low_pwr[1] && (f1_irq_src_i || (f1_pd_next && f1_pd_irq_en_i));

  // Registered results; clocks stop in low power except restarted ones
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      pd_status_o <= 1'b0;
      f0_irq_o <= 1'b0;
      f1_irq_o <= 1'b0;
      f1_pd_req_o <= 1'b0;
      chan_clk_en_o <= '1;
    end else if (clk_en_i) begin
      pd_status_o <= pd_status_next;
      f0_irq_o <= f0_irq_next;
      f1_irq_o <= f1_irq_next;
      f1_pd_req_o <= f1_pd_next;
      chan_clk_en_o <= low_pwr[0] ? (sin_wake_reg | (ps_reg[0] == pm_pkg::PS_D2 ? sin_wake : '0)) : '1;
    end
  end

  // BAR gates follow state directly; configuration access is never gated
  assign f0_bar_en_o = !low_pwr[0];
  assign f1_bar_en_o = !low_pwr[1];
  assign f1_low_power_o = low_pwr[1];

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  sequence busy_s;
    clk_en_i && !all_idle;
  endsequence
  sequence d3_ring_s;
    clk_en_i && ps_reg[0] == pm_pkg::PS_D3 && ri_trail != '0;
  endsequence
  sequence f1_rise_s;
    clk_en_i && f1_wake_en_i && f1_wake_edge_sel_i == pm_pkg::WAKE_EDGE_RISE && pin2_rise;
  endsequence
  sequence hold_st_s;
    clk_en_i && pme_st_reg[0] && !w1c[0];
  endsequence

  pd_needs_idle_a: assert property (busy_s |=> !pd_valid)
    else $error("power-down valid after channel activity");
  filter_restart_a: assert property (busy_s ##1 (clk_en_i && all_idle) |=> !pd_valid)
    else $error("filter did not restart");
  filter_off_irq_a: assert property ((clk_en_i && pd_filter_sel_i == pm_pkg::FILT_OFF
    && !low_pwr[0] && mpp_act[pm_pkg::MPP_F0] && mpp1_irq_mask_i) |=> f0_irq_o)
    else $error("pin 1 interrupt missing with filter off");
  pd_irq_mask_a: assert property ((clk_en_i && pd_filter_sel_i != pm_pkg::FILT_OFF
    && !mpp1_irq_mask_i && chan_uart_irq_i == '0) |=> !f0_irq_o && pd_status_o == $past(pd_valid))
    else $error("masked power-down raised interrupt");
  pd_irq_on_a: assert property ((clk_en_i && pd_filter_sel_i != pm_pkg::FILT_OFF
    && mpp1_irq_mask_i && pd_valid && !low_pwr[0]) |=> f0_irq_o && pd_status_o)
    else $error("enabled power-down interrupt missing");
  state_hold_a: assert property ((clk_en_i && !pmcsr_wr_i[0]) |=> $stable(ps_reg[0]))
    else $error("function 0 state changed without a write");
  // Gates follow the state at once; registered outputs one cycle later, so a return to D0 is legal
  f0_quiet_a: assert property ((clk_en_i && low_pwr[0]) |-> !f0_bar_en_o ##1 (!f0_irq_o
    && chan_clk_en_o == (sin_wake_reg & chan_clk_en_o)))
    else $error("function 0 active in low power");
  f1_quiet_a: assert property ((clk_en_i && low_pwr[1])
    |-> (f1_low_power_o && !f1_bar_en_o) ##1 !f1_irq_o)
    else $error("function 1 active in low power");
  wake_pin_a: assert property ((clk_en_i && (wake & pme_en_reg) != 2'h0
    && pmcsr_wr_i == 2'h0) |=> !pme_n_o)
    else $error("enabled wake did not drive the wake pin");
  ring_wake_a: assert property (d3_ring_s |=> pme_st_reg[0])
    else $error("ring trailing edge did not set status");
  status_sticky_a: assert property (hold_st_s |=> pme_st_reg[0])
    else $error("wake status lost without a clear");
  mask_reset_a: assert property (@(posedge mclk_i) disable iff (1'b0)
    !reset_n_i |=> wake_mask_reg == '0)
    else $error("wake masks not cleared by reset");
  f1_wake_a: assert property (f1_rise_s |=> pme_st_reg[1])
    else $error("pin 2 rise did not set function 1 status");
endmodule
`default_nettype wire

// ===== hdl/idle_time_filter.sv
`timescale 1ns/1ns
`default_nettype none
module idle_time_filter (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic idle_i,
  input wire logic [1:0] sel_i,
  input wire logic [pm_pkg::PD_CNT_W-1:0] limit_i,
  output logic valid_o
);
  logic [pm_pkg::PD_CNT_W-1:0] cnt_reg;
  logic valid_reg;

  // Count idle cycles; any activity or a disabled filter starts over
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      cnt_reg <= '0;
      valid_reg <= 1'b0;
    end else if (clk_en_i) begin
      if (!idle_i || sel_i == pm_pkg::FILT_OFF) begin
        cnt_reg <= '0;
        valid_reg <= 1'b0;
      end else if (cnt_reg >= limit_i) begin
        valid_reg <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  assign valid_o = valid_reg;
endmodule
`default_nettype wire

// ===== hdl/level_edge_detect.sv
`timescale 1ns/1ns
`default_nettype none
module level_edge_detect #(
  parameter int W = 1
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic [W-1:0] level_i,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);
  logic [W-1:0] prev_reg;
  logic primed_reg;

  // Remember last level; edges only count once a first sample exists
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      prev_reg <= '0;
      primed_reg <= 1'b0;
    end else if (clk_en_i) begin
      prev_reg <= level_i;
      primed_reg <= 1'b1;
    end
  end

  // Edges are seen in the cycle the new level arrives
  assign rise_o = primed_reg ? (level_i & ~prev_reg) : '0;
  assign fall_o = primed_reg ? (~level_i & prev_reg) : '0;
endmodule
`default_nettype wire

// ===== hdl/pm_pkg.sv
package pm_pkg;
  // Clock rate and filter times in seconds; counts are derived so a clock change rescales them
  localparam longint unsigned CLK_HZ = 100_000_000;
  localparam longint unsigned FILT_SHORT_S = 4;
  localparam longint unsigned FILT_MID_S = 129;
  localparam longint unsigned FILT_LONG_S = 518;
  localparam longint unsigned FILT_LONG_IRQ_S = 515;
  localparam int PD_CNT_W = 36;
  localparam logic [PD_CNT_W-1:0] FILT_SHORT_CYC = PD_CNT_W'(FILT_SHORT_S * CLK_HZ);
  localparam logic [PD_CNT_W-1:0] FILT_MID_CYC = PD_CNT_W'(FILT_MID_S * CLK_HZ);
  localparam logic [PD_CNT_W-1:0] FILT_LONG_CYC = PD_CNT_W'(FILT_LONG_S * CLK_HZ);
  localparam logic [PD_CNT_W-1:0] FILT_LONG_IRQ_CYC = PD_CNT_W'(FILT_LONG_IRQ_S * CLK_HZ);
  // Filter select field encodings
  localparam logic [1:0] FILT_OFF = 2'h0;
  localparam logic [1:0] FILT_SHORT = 2'h1;
  localparam logic [1:0] FILT_MID = 2'h2;
  localparam logic [1:0] FILT_LONG = 2'h3;
  // Power management control/status layout
  localparam int PMCSR_W = 16;
  localparam int PMCSR_PME_EN = 8;
  localparam int PMCSR_PME_ST = 15;
  localparam logic [1:0] PS_CODE_D0 = 2'h0;
  localparam logic [1:0] PS_CODE_D2 = 2'h2;
  localparam logic [1:0] PS_CODE_D3 = 2'h3;
  // Channel and pin geometry
  localparam int N_CHAN = 4;
  localparam int MODEM_W = 4;
  localparam int MPP_W = 12;
  localparam int MPP_F0 = 1;
  localparam int MPP_WAKE = 2;
  localparam int MPP_PD_LO = 3;
  localparam int N_F1_PD = 9;
  localparam logic [1:0] WAKE_EDGE_RISE = 2'h0;
  localparam logic [1:0] WAKE_EDGE_FALL = 2'h1;

  typedef enum logic [1:0] {PS_D0, PS_D2, PS_D3} pwr_state_t;

  // Encode a power state for readback
  function automatic logic [1:0] ps_code(input pwr_state_t s);
    case (s)
      PS_D2: ps_code = PS_CODE_D2;
      PS_D3: ps_code = PS_CODE_D3;
      default: ps_code = PS_CODE_D0;
    endcase
  endfunction

  // Decode a written state; unsupported codes keep the current state
  function automatic pwr_state_t ps_decode(input logic [1:0] c, input pwr_state_t cur);
    case (c)
      PS_CODE_D0: ps_decode = PS_D0;
      PS_CODE_D2: ps_decode = PS_D2;
      PS_CODE_D3: ps_decode = PS_D3;
      default: ps_decode = cur;
    endcase
  endfunction
endpackage

// ===== tb/pm_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// Driver side of the power management registers; it owns the write strobes and data
module pm_host_model (
  input wire logic mclk_i,
  output logic [1:0] pmcsr_wr_o,
  output logic [pm_pkg::PMCSR_W-1:0] pmcsr_wdata0_o,
  output logic [pm_pkg::PMCSR_W-1:0] pmcsr_wdata1_o
);
  // Idle data lines carry a junk pattern so a stale value never reads as a write
  initial begin
    pmcsr_wr_o = 2'h0;
    pmcsr_wdata0_o = 16'ha5a5;
    pmcsr_wdata1_o = 16'h5a5a;
  end

  // One-cycle write from the falling edge; t_f1 arms the pin 2 wake with function 1 in low power and again after it is back in D0
  task automatic wr_pmcsr(input logic f, input logic [pm_pkg::PMCSR_W-1:0] d);
    @(negedge mclk_i);
    pmcsr_wr_o[f] = 1'b1;
    if (f) pmcsr_wdata1_o = d;
    else pmcsr_wdata0_o = d;
    @(negedge mclk_i);
    pmcsr_wr_o = 2'h0;
    pmcsr_wdata0_o = ~d;
    pmcsr_wdata1_o = ~d;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk, rst_n, ce, wm_wr, mask, f1we, f1pie, f1src;
  logic [3:0] pend, txi, rxi, uirq, ring_n, sdi;
  logic [15:0] modem, rd0, rd1;
  logic [19:0] wm_d, wm;
  logic [1:0] sel, f1es, pwr;
  logic [11:0] pin, inv;
  logic [8:0] pden;
  logic [15:0] pwd0, pwd1;
  logic pd, irq0, irq1, f1pd, bar0, bar1, lowp, pme_n;
  logic [3:0] cke;
  int mismatches = 0;
  int checked = 0;

  // Shortened filter counts keep the run brief
  dual_function_power_manager #(.PD_SHORT_CYC(36'h14), .PD_MID_CYC(36'h28), .PD_LONG_CYC(36'h3c),
    .PD_LONG_IRQ_CYC(36'h32)) dut (.mclk_i(clk), .reset_n_i(rst_n), .clk_en_i(ce),
    .chan_irq_pending_i(pend), .chan_tx_idle_i(txi), .chan_rx_idle_i(rxi), .chan_uart_irq_i(uirq),
    .modem_status_i(modem), .ring_indicator_input_n_i(ring_n), .serial_data_input_i(sdi),
    .wake_mask_wr_i(wm_wr), .wake_mask_wdata_i(wm_d), .wake_mask_o(wm), .pd_filter_sel_i(sel),
    .mpp1_irq_mask_i(mask), .f1_wake_en_i(f1we), .f1_wake_edge_sel_i(f1es), .multi_purpose_pin_i(pin),
    .mpp_invert_i(inv), .f1_pd_pin_en_i(pden), .f1_pd_irq_en_i(f1pie), .f1_irq_src_i(f1src),
    .pmcsr_wr_i(pwr), .pmcsr_wdata0_i(pwd0), .pmcsr_wdata1_i(pwd1), .pmcsr_rdata0_o(rd0),
    .pmcsr_rdata1_o(rd1), .pd_status_o(pd), .f0_irq_o(irq0), .f1_irq_o(irq1), .f1_pd_req_o(f1pd),
    .chan_clk_en_o(cke), .f0_bar_en_o(bar0), .f1_bar_en_o(bar1), .f1_low_power_o(lowp), .pme_n_o(pme_n));

  pm_host_model host (.mclk_i(clk), .pmcsr_wr_o(pwr), .pmcsr_wdata0_o(pwd0), .pmcsr_wdata1_o(pwd1));

  always #5 clk = ~clk;

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (mismatches == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic t_reset;
    chk(rd0, 0);
    chk(rd1, 0);
    chk({pme_n, bar0, bar1, lowp, pd, irq0, irq1, f1pd}, 8'he0);
    chk(cke, 4'hf);
    chk(wm, 0);
  endtask

  // Filter timing, restart on activity, long setting with and without the mask
  task automatic t_filter;
    mask = 1'b1;
    sel = pm_pkg::FILT_SHORT;
    cyc(19);
    chk(pd, 0);
    cyc(5);
    chk({pd, irq0}, 2'h3);
    pend[1] = 1'b1;
    cyc(3);
    chk({pd, irq0}, 2'h0);
    pend[1] = 1'b0;
    cyc(12);
    txi[3] = 1'b0;
    cyc(1);
    txi[3] = 1'b1;
    cyc(19);
    chk(pd, 0);
    cyc(5);
    chk(pd, 1);
    sel = pm_pkg::FILT_LONG;
    mask = 1'b0;
    rxi[0] = 1'b0;
    cyc(1);
    rxi[0] = 1'b1;
    cyc(55);
    chk(pd, 0);
    mask = 1'b1;
    cyc(3);
    chk({pd, irq0}, 2'h3);
    mask = 1'b0;
    cyc(10);
    chk({pd, irq0}, 2'h2);
    // Filter off: pin 1 owns the shared status bit
    sel = pm_pkg::FILT_OFF;
    mask = 1'b1;
    pin[1] = 1'b1;
    cyc(3);
    chk({pd, irq0}, 2'h3);
    mask = 1'b0;
    pin[1] = 1'b0;
    cyc(3);
    chk({pd, irq0}, 2'h0);
    // Middle setting from a fresh count
    sel = pm_pkg::FILT_MID;
    cyc(40);
    chk(pd, 0);
    cyc(3);
    chk(pd, 1);
    sel = pm_pkg::FILT_OFF;
  endtask

  // Ring pulse while in D3; wake runs with the filter disabled
  task automatic t_f0_d3;
    uirq[0] = 1'b1;
    cyc(3);
    chk(irq0, 1);
    host.wr_pmcsr(1'b0, 16'h0103);
    cyc(2);
    chk({bar0, bar1, irq0, cke}, 7'h20);
    uirq[0] = 1'b0;
    modem[5] = ~modem[5];
    ring_n[2] = 1'b0;
    cyc(3);
    chk(pme_n, 1);
    ring_n[2] = 1'b1;
    cyc(3);
    chk(pme_n, 0);
    cyc(20);
    chk(rd0, 16'h8103);
    host.wr_pmcsr(1'b0, 16'h8000);
    cyc(2);
    chk({rd0, pme_n, bar0}, 18'h3);
    host.wr_pmcsr(1'b0, 16'h0003);
    ring_n[0] = 1'b0;
    cyc(2);
    ring_n[0] = 1'b1;
    cyc(3);
    chk({rd0, pme_n}, 17'h10007);
    host.wr_pmcsr(1'b0, 16'h8000);
    cyc(3);
    chk(cke, 4'hf);
  endtask

  // D2 wake masks, modem and data-input wakes, channel clock restart
  task automatic t_f0_d2;
    wm_d = 20'h2000f;
    wm_wr = 1'b1;
    cyc(1);
    wm_wr = 1'b0;
    chk(wm, 20'h2000f);
    host.wr_pmcsr(1'b0, 16'h0102);
    cyc(2);
    modem[0] = ~modem[0];
    sdi[1] = ~sdi[1];
    cyc(3);
    chk({pme_n, cke}, 5'h10);
    modem[4] = ~modem[4];
    cyc(3);
    chk({rd0, pme_n}, 17'h10204);
    host.wr_pmcsr(1'b0, 16'h8102);
    cyc(1);
    chk(pme_n, 1);
    sdi[2] = ~sdi[2];
    cyc(3);
    chk({pme_n, cke}, 5'h04);
    host.wr_pmcsr(1'b0, 16'h8000);
    cyc(3);
    chk({pme_n, cke}, 5'h1f);
  endtask

  // Function 1: pin power-down with polarity, low power, pin 2 wake edges
  task automatic t_f1;
    f1pie = 1'b1;
    pin[4] = 1'b1;
    inv[5] = 1'b1;
    pden = 9'h004;
    cyc(3);
    chk({f1pd, irq1}, 2'h3);
    pin[5] = 1'b1;
    cyc(3);
    chk({f1pd, irq1}, 2'h0);
    pin[5] = 1'b0;
    f1src = 1'b1;
    host.wr_pmcsr(1'b1, 16'h0103);
    cyc(2);
    chk({irq1, lowp, bar1, bar0}, 4'h5);
    f1src = 1'b0;
    f1we = 1'b1;
    f1es = pm_pkg::WAKE_EDGE_FALL;
    pin[2] = 1'b1;
    cyc(3);
    chk(pme_n, 1);
    pin[2] = 1'b0;
    cyc(3);
    chk({rd1, pme_n}, 17'h10206);
    host.wr_pmcsr(1'b1, 16'h8000);
    f1we = 1'b0;
    f1es = pm_pkg::WAKE_EDGE_RISE;
    pin[2] = 1'b1;
    cyc(3);
    chk({rd1, lowp}, 0);
    f1we = 1'b1;
    f1es = 2'h3;
    pin[2] = 1'b0;
    cyc(2);
    chk(rd1, 0);
    f1es = pm_pkg::WAKE_EDGE_RISE;
    pin[2] = 1'b1;
    cyc(3);
    chk({rd1, pme_n}, 17'h10001);
    host.wr_pmcsr(1'b1, 16'h8000);
  endtask

  // Enable low: a write made meanwhile is lost, and an interrupt source is not taken until it returns
  task automatic t_freeze;
    ce = 1'b0;
    uirq[0] = 1'b1;
    host.wr_pmcsr(1'b0, 16'h0103);
    cyc(1);
    chk({rd0, bar0, irq0}, 18'h2);
    ce = 1'b1;
    cyc(2);
    chk({rd0, irq0}, 17'h1);
    uirq[0] = 1'b0;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    {pend, uirq} = 8'h0;
    {txi, rxi, ring_n} = 12'hfff;
    {modem, sdi, wm_d, wm_wr} = 41'h0;
    {sel, mask, f1we, f1es, f1pie, f1src} = 8'h0;
    {pin, inv, pden} = 33'h0;
    cyc(8);
    rst_n = 1'b1;
    cyc(2);
    t_reset();
    t_filter();
    t_f0_d3();
    t_f0_d2();
    t_f1();
    t_freeze();
    wrap_up();
  end
endmodule
`default_nettype wire
